// ### pixel_gain_black_level.sv
// Pixel gain and black level datapath with register port and input FIFO
// Functional notes
// - Standard variant, codes below 512: ratio formula gain relative to minimum code.
// - Standard variant, codes 512 and up: 0.0354 dB per step, minus minimum-code gain.
// - Fast variants: 0.0359 dB per step above the minimum code.
// - Compact variant accepts gain codes 0 through 22 only.
// - Compact variant linear gain is one plus code over six.
// - Signed offset from pedestal code added to every pixel; higher code raises output.
// - Mono8, Bayer8, RGB8, YUV422 are 8-bit; Mono16, Mono12p, Bayer16, Bayer12p 12-bit.
// - Standard variant, 8-bit depth: 16 pedestal steps per output count.
// - Standard variant, 12-bit depth: one pedestal step per output count.
// - Compact variant: 4 pedestal steps per output count.
// - Fast variants, 8-bit depth: 64 pedestal steps per output count.
// - Fast variants, 12-bit depth: 4 pedestal steps per output count.
// - Pedestal code accepts 0 through 255 by default.
// - Compact variant pedestal code limited to 0 through 64.
// - High-resolution fast variant pedestal code accepts 0 through 1023.
`timescale 1ns/10ps
`include "pgb_defines.svh"
module pixel_gain_black_level #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     arst_n_i,
  input  wire pgb_pkg::reg_addr_t       reg_addr_i,
  input  wire logic [31:0]              reg_wdata_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  output logic      [31:0]              reg_rdata_o,
  input  wire logic                     pix_valid_i,
  output logic                          pix_ready_o,
  input  wire logic [`PGB_PIX_W-1:0]    pix_data_i,
  output logic                          pix_valid_o,
  input  wire logic                     pix_ready_i,
  output logic      [`PGB_PIX_W-1:0]    pix_data_o
);
  import pgb_pkg::*;

  variant_t            var_reg;
  pix_fmt_t            fmt_reg;
  logic [1:0]          gain_sel_reg;
  logic [1:0]          ped_sel_reg;
  logic [9:0]          gain_code_reg;
  logic [9:0]          gain_min_reg;
  logic [9:0]          ped_code_reg;
  logic [9:0]          ped_ref_reg;
  logic                reject_reg;
  logic                recalc_reg;
  logic [23:0]         factor_reg;
  calc_state_t         st_reg;
  logic [23:0]         num_reg;
  logic [23:0]         den_reg;
  logic [24:0]         rem_reg;
  logic [39:0]         dvd_reg;
  logic [39:0]         quo_reg;
  logic [5:0]          cnt_reg;
  logic                out_valid_reg;
  logic [11:0]         out_data_reg;
  logic                out_d12_reg;
  logic [11:0]         lut_addr;
  logic [23:0]         lut_data;
  logic                fifo_full;

  // 12-bit effective depth formats
  function automatic logic is_depth12(input pix_fmt_t f);
    return f inside {FMT_MONO16, FMT_MONO12P, FMT_BAYER16, FMT_BAYER12P};
  endfunction

  function automatic logic [9:0] gain_max(input variant_t v);
    return (v == VAR_COMPACT) ? `PGB_GAIN_MAX_CPT : `PGB_GAIN_MAX_STD;
  endfunction

  function automatic logic [9:0] ped_max(input variant_t v);
    logic [9:0] m;
    m = `PGB_PED_MAX_STD;
    if (v == VAR_COMPACT) m = `PGB_PED_MAX_CPT;
    if (v == VAR_FAST_HIRES) m = `PGB_PED_MAX_HIRES;
    return m;
  endfunction

  // Pedestal steps per output count as a power of two
  function automatic logic [2:0] ped_shift(input variant_t v, input logic d12);
    logic [2:0] s;
    s = d12 ? `PGB_SH_STD12 : `PGB_SH_STD8;
    if (v == VAR_COMPACT) s = `PGB_SH_CPT;
    if (v == VAR_FAST || v == VAR_FAST_HIRES) begin
      s = d12 ? `PGB_SH_FAST12 : `PGB_SH_FAST8;
    end
    return s;
  endfunction

  // Register port decode
  logic wr_ctrl;
  logic wr_gain;
  logic wr_min;
  logic wr_ped;
  logic gain_ok;
  logic min_ok;
  logic ped_ok;
  logic rej_set;
  logic rd_status;
  logic calc_set;

  assign wr_ctrl   = reg_wr_i && (reg_addr_i == `PGB_ADDR_CTRL);
  assign wr_gain   = reg_wr_i && (reg_addr_i == `PGB_ADDR_GAIN_CODE);
  assign wr_min    = reg_wr_i && (reg_addr_i == `PGB_ADDR_GAIN_MIN);
  assign wr_ped    = reg_wr_i && (reg_addr_i == `PGB_ADDR_PED_CODE);
  assign rd_status = reg_rd_i && (reg_addr_i == `PGB_ADDR_STATUS);
  assign gain_ok   = (gain_sel_reg == `PGB_SEL_ALL) && (reg_wdata_i[31:10] == '0)
                     && (reg_wdata_i[9:0] <= gain_max(var_reg));
  assign min_ok    = (reg_wdata_i[31:10] == '0) && (reg_wdata_i[9:0] <= gain_max(var_reg));
  assign ped_ok    = (ped_sel_reg == `PGB_SEL_ALL) && (reg_wdata_i[31:10] == '0)
                     && (reg_wdata_i[9:0] <= ped_max(var_reg));
  assign rej_set   = (wr_gain && !gain_ok) || (wr_min && !min_ok) || (wr_ped && !ped_ok);
  assign calc_set  = (wr_gain && gain_ok) || (wr_min && min_ok) || wr_ctrl;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      var_reg      <= VAR_STD;
      fmt_reg      <= FMT_MONO8;
      gain_sel_reg <= `PGB_SEL_ALL;
      ped_sel_reg  <= `PGB_SEL_ALL;
      ped_ref_reg  <= `PGB_RST_CODE;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `PGB_ADDR_CTRL: begin
          var_reg <= variant_t'(reg_wdata_i[`PGB_CTRL_VAR_LSB +: 2]);
          fmt_reg <= pix_fmt_t'(reg_wdata_i[`PGB_CTRL_FMT_LSB +: 3]);
        end
        `PGB_ADDR_GAIN_SEL: gain_sel_reg <= reg_wdata_i[1:0];
        `PGB_ADDR_PED_SEL:  ped_sel_reg  <= reg_wdata_i[1:0];
        `PGB_ADDR_PED_REF:  ped_ref_reg  <= reg_wdata_i[9:0];
        default: ;
      endcase
    end
  end

  // Gain and pedestal codes only change on an in-range write under the all-channel selector; the minimum code needs only an in-range write
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gain_code_reg <= `PGB_RST_CODE;
      gain_min_reg  <= `PGB_RST_CODE;
      ped_code_reg  <= `PGB_RST_CODE;
    end else begin
      if (wr_gain && gain_ok) gain_code_reg <= reg_wdata_i[9:0];
      if (wr_min && min_ok) gain_min_reg <= reg_wdata_i[9:0];
      if (wr_ped && ped_ok) ped_code_reg <= reg_wdata_i[9:0];
    end
  end

  // Sticky reject flag, cleared by a status read; a new reject wins
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reject_reg <= 1'b0;
    end else if (rej_set) begin
      reject_reg <= 1'b1;
    end else if (rd_status) begin
      reject_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `PGB_ADDR_CTRL:      reg_rdata_o <= {25'h000_0000, fmt_reg, 2'h0, var_reg};
        `PGB_ADDR_GAIN_SEL:  reg_rdata_o <= {30'h0000_0000, gain_sel_reg};
        `PGB_ADDR_GAIN_CODE: reg_rdata_o <= {22'h00_0000, gain_code_reg};
        `PGB_ADDR_GAIN_MIN:  reg_rdata_o <= {22'h00_0000, gain_min_reg};
        `PGB_ADDR_PED_SEL:   reg_rdata_o <= {30'h0000_0000, ped_sel_reg};
        `PGB_ADDR_PED_CODE:  reg_rdata_o <= {22'h00_0000, ped_code_reg};
        `PGB_ADDR_PED_REF:   reg_rdata_o <= {22'h00_0000, ped_ref_reg};
        `PGB_ADDR_STATUS:    reg_rdata_o <= {28'h000_0000, fifo_full, is_depth12(fmt_reg),
                                             reject_reg, (st_reg != ST_IDLE) || recalc_reg};
        `PGB_ADDR_FACTOR:    reg_rdata_o <= {8'h00, factor_reg};
        default:             reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // Gain factor = A(code) / A(min), recomputed after any gain or variant change
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      recalc_reg <= 1'b0;
    end else if (calc_set) begin
      recalc_reg <= 1'b1;
    end else if (st_reg == ST_IDLE) begin
      recalc_reg <= 1'b0;
    end
  end

  assign lut_addr = {var_reg, (st_reg == ST_RD_NUM) ? gain_code_reg : gain_min_reg};

  gain_lut u_lut (
    .clk_i  (clk_sys_i),
    .addr_i (lut_addr),
    .data_o (lut_data)
  );

  logic [24:0] rem_sh;
  logic        q_bit;
  assign rem_sh = {rem_reg[23:0], dvd_reg[39]};
  assign q_bit  = (rem_sh >= {1'b0, den_reg});

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= ST_IDLE;
    end else begin
      unique case (st_reg)
        ST_IDLE:   if (recalc_reg) st_reg <= ST_RD_NUM;
        ST_RD_NUM: st_reg <= ST_RD_DEN;
        ST_RD_DEN: st_reg <= ST_LOAD;
        ST_LOAD:   st_reg <= ST_DIV;
        ST_DIV:    if (cnt_reg == `PGB_DIV_LAST) st_reg <= ST_IDLE;
        default:   st_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      num_reg <= '0;
      den_reg <= '0;
      rem_reg <= '0;
      dvd_reg <= '0;
      quo_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (st_reg == ST_RD_DEN) num_reg <= lut_data;
      if (st_reg == ST_LOAD) begin
        den_reg <= lut_data;
        dvd_reg <= {num_reg, 16'h0000};
        rem_reg <= '0;
        quo_reg <= '0;
        cnt_reg <= '0;
      end else if (st_reg == ST_DIV) begin
        rem_reg <= q_bit ? (rem_sh - {1'b0, den_reg}) : rem_sh;
        dvd_reg <= {dvd_reg[38:0], 1'b0};
        quo_reg <= {quo_reg[38:0], q_bit};
        cnt_reg <= cnt_reg + 6'd1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      factor_reg <= `PGB_GAIN_ONE;
    end else if (st_reg == ST_DIV && cnt_reg == `PGB_DIV_LAST) begin
      factor_reg <= (quo_reg[38:23] != '0) ? 24'hFF_FFFF : {quo_reg[22:0], q_bit};
    end
  end

  // Input FIFO in front of the datapath
  pix_stream_if #(.W(`PGB_PIX_W)) in_bus ();
  pix_stream_if #(.W(`PGB_PIX_W)) dp_bus ();

  assign in_bus.valid = pix_valid_i;
  assign in_bus.data  = pix_data_i;
  assign pix_ready_o  = in_bus.ready;

  pix_fifo #(.W(`PGB_PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i    (clk_sys_i),
    .arst_n_i (arst_n_i),
    .wr       (in_bus),
    .rd       (dp_bus),
    .full_o   (fifo_full)
  );

  // Gain, offset and clamp
  logic               d12;
  logic [35:0]        prod;
  logic [19:0]        base;
  logic signed [10:0] ofs_raw;
  logic signed [10:0] ofs;
  logic signed [21:0] sum;
  logic [11:0]        top;
  logic [11:0]        clamped;
  logic               take;

  assign d12     = is_depth12(fmt_reg);
  assign prod    = dp_bus.data * factor_reg;
  assign base    = d12 ? prod[35:16] : 20'(prod[35:16] >> `PGB_DEPTH8_DROP);
  assign ofs_raw = $signed({1'b0, ped_code_reg}) - $signed({1'b0, ped_ref_reg});
  assign ofs     = ofs_raw >>> ped_shift(var_reg, d12);
  assign sum     = $signed({2'b00, base}) + 22'(ofs);
  assign top     = d12 ? `PGB_MAX12 : `PGB_MAX8;
  assign clamped = (sum < 0) ? 12'h000 : ((sum > $signed({10'h000, top})) ? top : sum[11:0]);

  assign dp_bus.ready = !out_valid_reg || pix_ready_i;
  assign take         = dp_bus.valid && dp_bus.ready;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
      out_d12_reg   <= 1'b0;
    end else if (dp_bus.ready) begin
      out_valid_reg <= dp_bus.valid;
      if (take) begin
        out_data_reg <= clamped;
        out_d12_reg  <= d12;
      end
    end
  end

  assign pix_valid_o = out_valid_reg;
  assign pix_data_o  = out_data_reg;

  a_clamp_depth8: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    pix_valid_o && !out_d12_reg |-> pix_data_o <= `PGB_MAX8)
    else $error("8-bit pixel above 255");
  a_gain_reject: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_gain && var_reg == VAR_COMPACT && reg_wdata_i > 32'd22
    |=> gain_code_reg == $past(gain_code_reg))
    else $error("Compact gain code above 22 accepted");
  a_ped_reject: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_ped && var_reg == VAR_STD && reg_wdata_i > 32'd255 |=> $stable(ped_code_reg))
    else $error("Pedestal code above 255 accepted");
  a_ped_hires_take: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_ped && var_reg == VAR_FAST_HIRES && ped_sel_reg == `PGB_SEL_ALL
    && reg_wdata_i <= 32'd1023 |=> ped_code_reg == $past(reg_wdata_i[9:0]))
    else $error("Wide pedestal code not taken");
  // Divide length counted apart from the divider's own step count
  logic [6:0] div_len_reg;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_len_reg <= 7'h00;
    end else if (st_reg == ST_DIV) begin
      div_len_reg <= div_len_reg + 7'd1;
    end else begin
      div_len_reg <= 7'h00;
    end
  end

  a_calc_start: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    st_reg == ST_LOAD |=> st_reg == ST_DIV && div_len_reg == 7'd0)
    else $error("Gain division did not start after load");
  a_calc_time: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    st_reg == ST_DIV |-> div_len_reg < 7'd40)
    else $error("Gain division longer than 40 cycles");
  a_calc_end: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    st_reg == ST_DIV && div_len_reg == 7'd39 |=> st_reg == ST_IDLE)
    else $error("Gain division not ended after 40 cycles");
  a_unity_gain: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    st_reg == ST_DIV && cnt_reg == `PGB_DIV_LAST && var_reg == VAR_COMPACT
    && gain_code_reg == 10'h000 && gain_min_reg == 10'h000 |=> factor_reg == `PGB_GAIN_ONE)
    else $error("Code zero not unity gain");
  a_out_hold: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_data_o))
    else $error("Output pixel changed while stalled");
  a_reject_sticky: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rej_set |=> reject_reg)
    else $error("Refused write did not raise reject flag");
  a_reject_clear: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_status && !rej_set |=> !reject_reg)
    else $error("Reject flag not cleared by status read");
  a_factor_read: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    reg_rd_i && reg_addr_i == `PGB_ADDR_FACTOR |=> reg_rdata_o[23:0] == $past(factor_reg))
    else $error("Factor readback wrong");
endmodule // pixel_gain_black_level

// ### pgb_defines.svh
// Offsets, field positions, reset values and arithmetic constants of the pixel gain block
`ifndef PGB_DEFINES_SVH
`define PGB_DEFINES_SVH
`define PGB_PIX_W          12
`define PGB_ADDR_CTRL      8'h00
`define PGB_ADDR_GAIN_SEL  8'h04
`define PGB_ADDR_GAIN_CODE 8'h08
`define PGB_ADDR_GAIN_MIN  8'h0C
`define PGB_ADDR_PED_SEL   8'h10
`define PGB_ADDR_PED_CODE  8'h14
`define PGB_ADDR_PED_REF   8'h18
`define PGB_ADDR_STATUS    8'h1C
`define PGB_ADDR_FACTOR    8'h20
`define PGB_CTRL_VAR_LSB   0
`define PGB_CTRL_FMT_LSB   4
`define PGB_ST_BUSY_BIT    0
`define PGB_ST_REJECT_BIT  1
`define PGB_ST_DEPTH_BIT   2
`define PGB_ST_FULL_BIT    3
`define PGB_SEL_ALL        2'h0
`define PGB_GAIN_ONE       24'h01_0000
`define PGB_RST_CODE       10'h000
`define PGB_K_OFS          658.0
`define PGB_STD_DB_STEP    0.0354
`define PGB_FAST_DB_STEP   0.0359
`define PGB_STD_KNEE       512
`define PGB_CPT_DIV        6.0
`define PGB_Q_SCALE        65536.0
`define PGB_GAIN_MAX_STD   10'h3FF
`define PGB_GAIN_MAX_CPT   10'h016
`define PGB_PED_MAX_STD    10'h0FF
`define PGB_PED_MAX_CPT    10'h040
`define PGB_PED_MAX_HIRES  10'h3FF
`define PGB_SH_STD8        3'd4
`define PGB_SH_STD12       3'd0
`define PGB_SH_CPT         3'd2
`define PGB_SH_FAST8       3'd6
`define PGB_SH_FAST12      3'd2
`define PGB_DEPTH8_DROP    4
`define PGB_MAX8           12'h0FF
`define PGB_MAX12          12'hFFF
`define PGB_DIV_LAST       6'd39
`endif

// ### pgb_pkg.sv
// Types shared by the pixel gain block
package pgb_pkg;
  typedef logic [7:0] reg_addr_t;
  typedef enum logic [1:0] {
    VAR_STD = 2'h0, VAR_FAST = 2'h1, VAR_FAST_HIRES = 2'h2, VAR_COMPACT = 2'h3
  } variant_t;
  typedef enum logic [2:0] {
    FMT_MONO8 = 3'h0, FMT_BAYER8 = 3'h1, FMT_RGB8 = 3'h2, FMT_YUV422 = 3'h3,
    FMT_MONO16 = 3'h4, FMT_MONO12P = 3'h5, FMT_BAYER16 = 3'h6, FMT_BAYER12P = 3'h7
  } pix_fmt_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_RD_NUM = 3'b001, ST_RD_DEN = 3'b011, ST_LOAD = 3'b010,
    ST_DIV = 3'b110
  } calc_state_t;
endpackage

// ### pix_stream_if.sv
// Valid/ready pixel stream between the block's own modules
`timescale 1ns/10ps
interface pix_stream_if #(parameter int W = 12);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### pix_fifo.sv
// Pixel FIFO with valid/ready on both sides
`timescale 1ns/10ps
module pix_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 16
) (
  input  wire logic  clk_i,
  input  wire logic  arst_n_i,
  pix_stream_if.snk  wr,
  pix_stream_if.src  rd,
  output logic       full_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW:0]  wptr_reg;
  logic [AW:0]  rptr_reg;
  logic         empty;
  logic         push;
  logic         pop;

  assign full_o   = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign empty    = (wptr_reg == rptr_reg);
  assign wr.ready = !full_o;
  assign rd.valid = !empty;
  assign rd.data  = mem_reg[rptr_reg[AW-1:0]];
  assign push     = wr.valid && !full_o;
  assign pop      = rd.ready && !empty;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wptr_reg[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) wptr_reg <= wptr_reg + 1'b1;
      if (pop) rptr_reg <= rptr_reg + 1'b1;
    end
  end

  a_fifo_full_stall: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    full_o && !pop |=> full_o && $stable(wptr_reg))
    else $error("FIFO accepted a word while full");
endmodule // pix_fifo

// ### gain_lut.sv
// Absolute linear gain table per variant, Q8.16, registered read
`timescale 1ns/10ps
`include "pgb_defines.svh"
module gain_lut (
  input  wire logic        clk_i,
  input  wire logic [11:0] addr_i,
  output logic      [23:0] data_o
);
  logic [23:0] rom [4096];

  function automatic logic [23:0] gain_q16(input int v, input int c);
    real g;
    g = 1.0;
    if (v == 3) begin
      g = 1.0 + c / `PGB_CPT_DIV;
    end else if (v == 0 && c < `PGB_STD_KNEE) begin
      g = (`PGB_K_OFS + c) / (`PGB_K_OFS - c);
    end else if (v == 0) begin
      g = 10.0 ** (`PGB_STD_DB_STEP * c / 20.0);
    end else begin
      g = 10.0 ** (`PGB_FAST_DB_STEP * c / 20.0);
    end
    return 24'($rtoi(g * `PGB_Q_SCALE));
  endfunction

  initial begin
    for (int i = 0; i < 4096; i++) begin
      rom[i] = gain_q16(i / 1024, i % 1024);
    end
  end

  always_ff @(posedge clk_i) begin
    data_o <= rom[addr_i];
  end
endmodule // gain_lut

// ### host_model.sv
// Host software model driving the register port of the pixel gain block
`timescale 1ns/10ps
`include "pgb_defines.svh"
module host_model (
  input  wire logic         clk_i,
  output pgb_pkg::reg_addr_t addr_o,
  output logic [31:0]       wdata_o,
  output logic              wr_o,
  output logic              rd_o,
  input  wire logic [31:0]  rdata_i
);
  import pgb_pkg::*;
  initial begin
    addr_o  = '0;
    wdata_o = '0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  // Idle cycle after each strobe so no signal is assigned twice in one step
  task automatic wr(input reg_addr_t a, input logic [31:0] d);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input reg_addr_t a, output logic [31:0] d);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask
  task automatic set_gain(input logic [31:0] c);
    wr(`PGB_ADDR_GAIN_SEL, 32'h0000_0000);
    wr(`PGB_ADDR_GAIN_CODE, c);
  endtask
  task automatic set_ped(input logic [31:0] c);
    wr(`PGB_ADDR_PED_SEL, 32'h0000_0000);
    wr(`PGB_ADDR_PED_CODE, c);
  endtask
endmodule // host_model

// ### pixel_gain_black_level_bench.sv
// Self-checking bench for the pixel gain and black level block
`timescale 1ns/10ps
`include "pgb_defines.svh"
module pixel_gain_black_level_bench;
  import pgb_pkg::*;
  logic        clk_sys_i, arst_n_i, wr, rd, pvi, pro, pvo, pri;
  reg_addr_t   addr;
  logic [31:0] wdata, rdata, r;
  logic [11:0] pdi, pdo;
  logic [11:0] q[$];
  int          fail_count, total_checks, cycles, n;
  host_model host (.clk_i(clk_sys_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .rdata_i(rdata));
  pixel_gain_black_level dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .pix_valid_i(pvi), .pix_ready_o(pro), .pix_data_i(pdi),
    .pix_valid_o(pvo), .pix_ready_i(pri), .pix_data_o(pdo));
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rdc(input reg_addr_t a, input logic [31:0] e, input logic [31:0] m);
    host.rd(a, r);
    cmp32($sformatf("reg %h", a), e & m, r & m);
  endtask
  task automatic pop(input logic [11:0] e);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pvo !== 1'b1 && n < 60);
    cmp32("pixel", {19'd0, 1'b1, e}, {19'd0, pvo, pdo});
  endtask
  // One pixel through with the given variant, format and pedestal code
  task automatic ofs(variant_t v, pix_fmt_t f, logic [31:0] c, logic [11:0] d, logic [11:0] e);
    host.wr(`PGB_ADDR_CTRL, {25'd0, f, 2'd0, v});
    host.set_ped(c);
    pvi <= 1'b1;
    pdi <= d;
    @(posedge clk_sys_i);
    while (pro !== 1'b1) @(posedge clk_sys_i);
    pvi <= 1'b0;
    pop(e);
  endtask
  task automatic rng(variant_t v, reg_addr_t a, logic [31:0] val, bit ok);
    host.wr(`PGB_ADDR_CTRL, {30'd0, v});
    host.wr(`PGB_ADDR_GAIN_SEL, 32'h0000_0000);
    host.wr(`PGB_ADDR_PED_SEL, 32'h0000_0000);
    host.wr(a, 32'h0000_0000);
    host.rd(`PGB_ADDR_STATUS, r);
    host.wr(a, val);
    rdc(a, ok ? val : 32'h0000_0000, 32'h0000_03FF);
    rdc(`PGB_ADDR_STATUS, ok ? 32'h0000_0000 : 32'h0000_0002, 32'h0000_0002);
  endtask
  task automatic wait_idle();
    n = 0;
    do begin
      host.rd(`PGB_ADDR_STATUS, r);
      n++;
    end while (r[0] !== 1'b0 && n < 100);
    cmp32("busy", 32'h0000_0000, {31'd0, r[0]});
  endtask
  // Gain factor against the dB the rule gives, within divider rounding
  task automatic gchk(variant_t v, int m, int c, real db);
    int e;
    host.wr(`PGB_ADDR_CTRL, {30'd0, v});
    host.wr(`PGB_ADDR_GAIN_MIN, 32'(m));
    host.set_gain(32'(c));
    wait_idle();
    host.rd(`PGB_ADDR_FACTOR, r);
    e = $rtoi(`PGB_Q_SCALE * (10.0 ** (db / 20.0)));
    total_checks++;
    if ($isunknown(r) || r[31:24] != 8'h00 || int'(r[23:0]) > e + 8 || int'(r[23:0]) < e - 8) begin
      fail_count++;
      $display("MISMATCH factor expected %h seen %h", e, r);
    end
  endtask
  initial begin
    arst_n_i = 1'b0;
    pvi = 1'b0;
    pri = 1'b1;
    pdi = '0;
    repeat (12) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rdc(`PGB_ADDR_FACTOR, 32'h0001_0000, 32'hFFFF_FFFF);
    rdc(`PGB_ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    rdc(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
    $display("test reset done");
    for (int f = 0; f < 8; f++) begin
      host.wr(`PGB_ADDR_CTRL, 32'(f << 4));
      rdc(`PGB_ADDR_STATUS, (f >= 4) ? 32'h0000_0004 : 32'h0000_0000, 32'h0000_0004);
    end
    $display("test depth done");
    host.wr(`PGB_ADDR_PED_REF, 32'd100);
    ofs(VAR_STD, FMT_MONO16, 110, 12'd1000, 12'd1010);
    ofs(VAR_STD, FMT_MONO16, 90, 12'd1000, 12'd990);
    ofs(VAR_STD, FMT_BAYER12P, 110, 12'd4090, 12'd4095);
    ofs(VAR_STD, FMT_MONO12P, 90, 12'd5, 12'd0);
    ofs(VAR_STD, FMT_MONO8, 131, 12'h800, 12'd129);
    ofs(VAR_STD, FMT_RGB8, 68, 12'h800, 12'd126);
    ofs(VAR_FAST, FMT_YUV422, 228, 12'h800, 12'd130);
    ofs(VAR_FAST_HIRES, FMT_BAYER8, 163, 12'h800, 12'd128);
    ofs(VAR_FAST, FMT_BAYER16, 108, 12'd1000, 12'd1002);
    ofs(VAR_COMPACT, FMT_MONO16, 64, 12'd1000, 12'd991);
    ofs(VAR_COMPACT, FMT_MONO8, 64, 12'h800, 12'd119);
    $display("test offset done");
    rng(VAR_STD, `PGB_ADDR_PED_CODE, 32'd255, 1'b1);
    rng(VAR_STD, `PGB_ADDR_PED_CODE, 32'd256, 1'b0);
    rng(VAR_FAST_HIRES, `PGB_ADDR_PED_CODE, 32'd1023, 1'b1);
    rng(VAR_COMPACT, `PGB_ADDR_PED_CODE, 32'd65, 1'b0);
    rng(VAR_COMPACT, `PGB_ADDR_PED_CODE, 32'd64, 1'b1);
    rng(VAR_COMPACT, `PGB_ADDR_GAIN_CODE, 32'd23, 1'b0);
    rng(VAR_COMPACT, `PGB_ADDR_GAIN_CODE, 32'd22, 1'b1);
    host.wr(`PGB_ADDR_GAIN_SEL, 32'h0000_0001);
    host.wr(`PGB_ADDR_GAIN_CODE, 32'd5);
    rdc(`PGB_ADDR_GAIN_CODE, 32'd22, 32'h0000_03FF);
    $display("test range done");
    gchk(VAR_STD, 192, 500, 20.0 * $log10(1158.0 / 158.0) - 20.0 * $log10(850.0 / 466.0));
    gchk(VAR_STD, 192, 700, 0.0354 * 700.0 - 20.0 * $log10(850.0 / 466.0));
    gchk(VAR_FAST, 150, 500, 0.0359 * (500.0 - 150.0));
    host.wr(`PGB_ADDR_GAIN_MIN, 32'h0000_0000);
    host.wr(`PGB_ADDR_CTRL, 32'h0000_0043);
    host.set_ped(32'd0);
    host.wr(`PGB_ADDR_PED_REF, 32'd0);
    host.set_gain(32'd6);
    wait_idle();
    rdc(`PGB_ADDR_FACTOR, 32'h0002_0000, 32'h00FF_FFFF);
    ofs(VAR_COMPACT, FMT_MONO16, 0, 12'd1000, 12'd2000);
    host.set_gain(32'd3);
    wait_idle();
    rdc(`PGB_ADDR_FACTOR, 32'h0001_8000, 32'h00FF_FFFF);
    $display("test gain done");
    pri <= 1'b0;
    pvi <= 1'b1;
    for (int k = 1; k < 30; k++) begin
      pdi <= 12'(k * 4);
      @(posedge clk_sys_i);
      if (pro !== 1'b1) break;
      q.push_back(12'(k * 4));
    end
    pvi <= 1'b0;
    rdc(`PGB_ADDR_STATUS, 32'h0000_0008, 32'h0000_0008);
    cmp32("accepted", 32'd1, {31'd0, q.size() >= 16});
    pri <= 1'b1;
    foreach (q[i]) pop(12'(q[i] * 3 / 2));
    rdc(`PGB_ADDR_STATUS, 32'h0000_0000, 32'h0000_0008);
    $display("test fifo done");
    finish_test();
  end
endmodule // pixel_gain_black_level_bench
